// File: logic/ifd_top.sv
/*
  Input function decoder: eight digital inputs, each with a function code
  selector, decoded into requests for the motion core. APB register slave,
  sticky event flags cleared on read, masked level interrupt.
  Register map, byte offsets: 00 selectors of inputs 0 to 3, a byte each;
  04 selectors of inputs 4 to 7; 08 config (bit 0 sequence mode, bit 1
  high-speed pulse type, bit 2 inverted jog); 0C decoded status;
  10 event flags, cleared by a read; 14 event mask; 18 input levels.
  Events: 0 negative limit, 1 positive limit, 2 capture A, 3 capture B,
  4 stop with power-off; each is set by the rise of its request.
  Assumes inputs are synchronous to sys_clk_i and a 32-bit APB master.
*/
// Function
// R01: Code 19h: off velocity, on torque
// R02: Codes 1Ah/1Bh give index bits 3,4
// R03: Code 1Ch capture A, seventh input only
// R04: Code 1Dh capture B, sixth input only
// R05: Code 20h: off torque, on configured position
// R06: Code 21h: halt ramp then power off
// R07: Code 22h negative limit, alert, ramp
// R08: Code 23h positive limit, alert, ramp
// R09: Code 24h is homing reference switch
// R10: Code 27h starts move to home
// R11: Code 2Ch selects high-speed pulse reception
// R12: Code 37h jogs positive by default
// R13: Code 38h jogs negative by default
// R14: Code 39h starts next data set
// R15: Code 40h starts previous data set
// R16: One code selector per input drives requests
// R17: Requests are levels; edges for single actions
`timescale 1ns/100ps
module ifd_top
  import ifd_pkg::*;
#(
  parameter int N = IFD_NUM_IN
)
(
  input wire logic sys_clk_i, // 25 MHz clock
  input wire logic rst_n_i, // Synchronous reset, active low
  input wire logic clk_en_i, // Freezes all state when low
  input wire logic [N-1:0] din_i, // Digital inputs, high = active
  input wire logic psel_i, // APB select
  input wire logic penable_i, // APB enable
  input wire logic pwrite_i, // APB write
  input wire logic [7:0] paddr_i, // APB byte address
  input wire logic [31:0] pwdata_i, // APB write data
  output logic [31:0] prdata_o, // APB read data
  output logic pready_o, // APB ready
  output logic pslverr_o, // APB error on unmapped address
  output logic irq_o, // Level interrupt
  output logic [1:0] op_mode_o, // ifd_mode_t requested mode
  output logic mode_forced_o, // A mode-switch input is assigned
  output logic [1:0] set_index_hi_o, // set_index_bit4, set_index_bit3
  output logic capture_trigger_a_o, // Capture channel A level
  output logic capture_trigger_b_o, // Capture channel B level
  output logic stop_and_power_off_o, // Decelerate with halt ramp
  output logic power_stage_off_o, // Disable power stage once stopped
  output logic neg_travel_limit_o, // Negative limit active
  output logic pos_travel_limit_o, // Positive limit active
  output logic origin_switch_o, // Homing reference switch level
  output logic return_to_origin_o, // Pulse: start move to home
  output logic pulse_speed_select_o, // 1 = high-speed pulses
  output logic [1:0] jog_o, // ifd_jog_t request level
  output logic set_advance_o, // Pulse: start next data set
  output logic set_retreat_o, // Pulse: start previous data set
  input wire logic motor_stopped_i // Motion core reports standstill
);
  localparam int NE = 3; // Edge-detected functions: home, advance, retreat

  typedef struct packed
  {
    // Software-visible registers
    logic [N*IFD_CODE_W-1:0] sel;
    logic [CFG_W-1:0] cfg;
    // Sticky event flags and their mask
    logic [EV_W-1:0] ev_stat;
    logic [EV_W-1:0] ev_mask;
    // Last event levels, for rise detection
    logic [EV_W-1:0] lvl_prev;
    // APB answer, registered so outputs come from flops
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    // Decoded requests to the motion core
    logic [1:0] mode;
    logic mode_forced;
    logic [1:0] idx_hi;
    logic cap_a;
    logic cap_b;
    logic stop_off;
    logic pwr_off;
    logic neg_lim;
    logic pos_lim;
    logic origin;
    logic home;
    logic pspeed;
    logic [1:0] jog;
    logic adv;
    logic ret;
  } ifd_st_t;

  ifd_st_t st_r;
  ifd_st_t st_nxt;

  // Per-function decode results
  logic f_vt, f_tp, f_i3, f_i4, f_ca, f_cb, f_so, f_nl, f_pl, f_og;
  logic f_hm, f_ps, f_jf, f_jb, f_ad, f_rt;
  logic any_vt, any_tp, any_ps;
  logic [NE-1:0] lvl_vec;
  logic [NE-1:0] rise_vec;

  // Mask of inputs allowed for a code
  function automatic logic [N-1:0] only_input(input int k);
    logic [N-1:0] m;
    m = '0;
    m[k] = 1'b1;
    return m;
  endfunction

  // Whether any input carries the code, regardless of level
  function automatic logic assigned(input logic [N*IFD_CODE_W-1:0] s,
                                    input logic [IFD_CODE_W-1:0] c);
    logic a;
    a = 1'b0;
    for (int i = 0; i < N; i++)
    begin
      if (s[i*IFD_CODE_W +: IFD_CODE_W] == c)
        a = 1'b1;
    end
    return a;
  endfunction

  // Codes that any input may carry
  localparam logic [N-1:0] ALL_IN = '1;

  // Mode switching inputs
  ifd_sel #(.N(N)) u_vt (.codes_i(st_r.sel), .level_i(din_i), .code_i(FC_VEL_TRQ),
    .allow_i(ALL_IN), .hit_o(f_vt)); // [R16]
  ifd_sel #(.N(N)) u_tp (.codes_i(st_r.sel), .level_i(din_i), .code_i(FC_TRQ_POS),
    .allow_i(ALL_IN), .hit_o(f_tp));

  // Upper data set index bits
  ifd_sel #(.N(N)) u_i3 (.codes_i(st_r.sel), .level_i(din_i), .code_i(FC_IDX3),
    .allow_i(ALL_IN), .hit_o(f_i3));
  ifd_sel #(.N(N)) u_i4 (.codes_i(st_r.sel), .level_i(din_i), .code_i(FC_IDX4),
    .allow_i(ALL_IN), .hit_o(f_i4));

  // Capture codes work on one input each; elsewhere they are inert
  ifd_sel #(.N(N)) u_ca (.codes_i(st_r.sel), .level_i(din_i), .code_i(FC_CAP_A),
    .allow_i(only_input(CAP_A_INPUT)), .hit_o(f_ca)); // [R03]
  ifd_sel #(.N(N)) u_cb (.codes_i(st_r.sel), .level_i(din_i), .code_i(FC_CAP_B),
    .allow_i(only_input(CAP_B_INPUT)), .hit_o(f_cb)); // [R04]

  // Stop and travel limits
  ifd_sel #(.N(N)) u_so (.codes_i(st_r.sel), .level_i(din_i), .code_i(FC_STOP_OFF),
    .allow_i(ALL_IN), .hit_o(f_so));
  ifd_sel #(.N(N)) u_nl (.codes_i(st_r.sel), .level_i(din_i), .code_i(FC_NEG_LIM),
    .allow_i(ALL_IN), .hit_o(f_nl));
  ifd_sel #(.N(N)) u_pl (.codes_i(st_r.sel), .level_i(din_i), .code_i(FC_POS_LIM),
    .allow_i(ALL_IN), .hit_o(f_pl));

  // Homing
  ifd_sel #(.N(N)) u_og (.codes_i(st_r.sel), .level_i(din_i), .code_i(FC_ORIGIN),
    .allow_i(ALL_IN), .hit_o(f_og));
  ifd_sel #(.N(N)) u_hm (.codes_i(st_r.sel), .level_i(din_i), .code_i(FC_HOME),
    .allow_i(ALL_IN), .hit_o(f_hm));

  // Pulse type and jogging
  ifd_sel #(.N(N)) u_ps (.codes_i(st_r.sel), .level_i(din_i), .code_i(FC_PULSE_SPD),
    .allow_i(ALL_IN), .hit_o(f_ps));
  ifd_sel #(.N(N)) u_jf (.codes_i(st_r.sel), .level_i(din_i), .code_i(FC_JOG_FWD),
    .allow_i(ALL_IN), .hit_o(f_jf));
  ifd_sel #(.N(N)) u_jb (.codes_i(st_r.sel), .level_i(din_i), .code_i(FC_JOG_BWD),
    .allow_i(ALL_IN), .hit_o(f_jb));

  // Data set stepping
  ifd_sel #(.N(N)) u_ad (.codes_i(st_r.sel), .level_i(din_i), .code_i(FC_ADVANCE),
    .allow_i(ALL_IN), .hit_o(f_ad));
  ifd_sel #(.N(N)) u_rt (.codes_i(st_r.sel), .level_i(din_i), .code_i(FC_RETREAT),
    .allow_i(ALL_IN), .hit_o(f_rt));

  // Mode-switch inputs only steer the mode when one is assigned
  assign any_vt = assigned(st_r.sel, FC_VEL_TRQ);
  assign any_tp = assigned(st_r.sel, FC_TRQ_POS);
  assign any_ps = assigned(st_r.sel, FC_PULSE_SPD);

  // Single-action starts need an edge; the rest stay levels, since
  // the motion core must see a held limit or stop while it lasts
  assign lvl_vec = {f_rt, f_ad, f_hm};
  ifd_edge #(.W(NE)) u_edge (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .clk_en_i(clk_en_i),
    .level_i(lvl_vec),
    .rise_o(rise_vec)
  ); // [R17]

  // Next-state logic: decoding, APB slave, events
  always_comb
  begin
    logic [EV_W-1:0] lvl;
    logic [EV_W-1:0] ev_rise;
    logic rd_stat;
    logic [1:0] pos_mode;
    st_nxt = st_r;
    // Event levels; the rise of any one sets its flag
    lvl = '0;
    lvl[EV_NEG_LIM] = f_nl;
    lvl[EV_POS_LIM] = f_pl;
    lvl[EV_CAP_A] = f_ca;
    lvl[EV_CAP_B] = f_cb;
    lvl[EV_STOP_OFF] = f_so;
    ev_rise = lvl & ~st_r.lvl_prev;
    st_nxt.lvl_prev = lvl;
    rd_stat = 1'b0;
    // Position mode that the config names
    pos_mode = st_r.cfg[CFG_POS_MODE] ? MODE_SEQ : MODE_PULSE;

    // Operating mode: torque-position switch takes precedence
    st_nxt.mode_forced = any_vt | any_tp;
    if (any_tp)
      st_nxt.mode = f_tp ? pos_mode : MODE_TRQ; // [R05]
    else if (any_vt)
      st_nxt.mode = f_vt ? MODE_TRQ : MODE_VEL; // [R01]
    else
      st_nxt.mode = pos_mode;

    // Level requests follow their inputs one edge late
    st_nxt.idx_hi = {f_i4, f_i3}; // [R02]
    st_nxt.cap_a = f_ca; // [R03]
    st_nxt.cap_b = f_cb; // [R04]
    // Power stage goes off only after standstill while the request holds
    st_nxt.stop_off = f_so; // [R06]
    st_nxt.pwr_off = f_so & (st_r.pwr_off | motor_stopped_i); // [R06]
    st_nxt.neg_lim = f_nl; // [R07]
    st_nxt.pos_lim = f_pl; // [R08]
    st_nxt.origin = f_og; // [R09]
    // Home start is a one-cycle pulse on the rising request
    st_nxt.home = rise_vec[0]; // [R10]
    // Input overrides the configured pulse type when assigned
    st_nxt.pspeed = any_ps ? f_ps : st_r.cfg[CFG_PULSE_HS]; // [R11]
    // Both jog inputs at once cancel each other
    if (f_jf && !f_jb)
      st_nxt.jog = st_r.cfg[CFG_DIR_INV] ? JOG_NEG : JOG_POS; // [R12]
    else if (f_jb && !f_jf)
      st_nxt.jog = st_r.cfg[CFG_DIR_INV] ? JOG_POS : JOG_NEG; // [R13]
    else
      st_nxt.jog = JOG_NONE;

    // Steps mean nothing outside sequence mode, so they are dropped there
    st_nxt.adv = rise_vec[1] & (st_r.mode == MODE_SEQ); // [R14]
    st_nxt.ret = rise_vec[2] & (st_r.mode == MODE_SEQ); // [R15]

    // APB slave: answers in the access cycle after setup
    st_nxt.pready = 1'b0;
    st_nxt.pslverr = 1'b0;
    if (psel_i && !penable_i)
    begin
      st_nxt.pready = 1'b1;
      // Read data is taken at setup, so it stands in the access cycle
      st_nxt.prdata = '0;
      case (paddr_i)
        OFS_SEL_LO: st_nxt.prdata = st_r.sel[31:0];
        OFS_SEL_HI: st_nxt.prdata = st_r.sel[63:32];
        OFS_CONFIG: st_nxt.prdata[CFG_W-1:0] = st_r.cfg;
        OFS_STATUS: st_nxt.prdata[12:0] = {st_r.jog, st_r.pspeed, st_r.pwr_off,
          st_r.stop_off, st_r.origin, st_r.pos_lim, st_r.neg_lim, st_r.cap_b,
          st_r.cap_a, st_r.idx_hi, st_r.mode[0]};
        OFS_IRQ_STAT: st_nxt.prdata[EV_W-1:0] = st_r.ev_stat;
        OFS_IRQ_MASK: st_nxt.prdata[EV_W-1:0] = st_r.ev_mask;
        OFS_LEVELS: st_nxt.prdata[N-1:0] = din_i;
        // Unmapped: error answer, nothing changes
        default: st_nxt.pslverr = 1'b1;
      endcase
    end

    // Access edge: a write lands, a flag read clears
    if (psel_i && penable_i && st_r.pready)
    begin
      if (pwrite_i)
      begin
        case (paddr_i)
          OFS_SEL_LO: st_nxt.sel[31:0] = pwdata_i;
          OFS_SEL_HI: st_nxt.sel[63:32] = pwdata_i;
          OFS_CONFIG: st_nxt.cfg = pwdata_i[CFG_W-1:0];
          OFS_IRQ_MASK: st_nxt.ev_mask = pwdata_i[EV_W-1:0];
          default: ;
        endcase
      end
      else if (paddr_i == OFS_IRQ_STAT)
        rd_stat = 1'b1;
    end

    // Read clears, but a new event in the same cycle survives
    st_nxt.ev_stat = (rd_stat ? '0 : st_r.ev_stat) | ev_rise; // [R07] [R08]
    st_nxt.irq = |(st_nxt.ev_stat & st_nxt.ev_mask);
  end

  // State register; a low enable freezes all but reset
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      st_r <= '0;
      st_r.sel <= {N{SEL_RST[IFD_CODE_W-1:0]}}; // Same byte in every selector
      st_r.cfg <= CFG_RST[CFG_W-1:0];
      st_r.ev_stat <= EV_RST;
      st_r.ev_mask <= EV_RST;
    end
    else if (clk_en_i)
      st_r <= st_nxt;
  end

  // Outputs straight from the state register
  assign prdata_o = st_r.prdata;
  assign pready_o = st_r.pready;
  assign pslverr_o = st_r.pslverr;
  assign irq_o = st_r.irq;

  // Mode and data set index
  assign op_mode_o = st_r.mode;
  assign mode_forced_o = st_r.mode_forced;
  assign set_index_hi_o = st_r.idx_hi;

  // Capture, stop and protection levels
  assign capture_trigger_a_o = st_r.cap_a;
  assign capture_trigger_b_o = st_r.cap_b;
  assign stop_and_power_off_o = st_r.stop_off;
  assign power_stage_off_o = st_r.pwr_off;
  assign neg_travel_limit_o = st_r.neg_lim;
  assign pos_travel_limit_o = st_r.pos_lim;

  // Homing, pulse type and motion starts
  assign origin_switch_o = st_r.origin;
  assign return_to_origin_o = st_r.home;
  assign pulse_speed_select_o = st_r.pspeed;
  assign jog_o = st_r.jog;
  assign set_advance_o = st_r.adv;
  assign set_retreat_o = st_r.ret;
endmodule

// File: logic/ifd_pkg.sv
/*
  Package for the input function decoder: function codes, register map,
  field positions, reset values and mode encodings.
  Assumes a 32-bit APB master and one synchronous clock.
*/
package ifd_pkg;
  localparam int IFD_NUM_IN = 8;
  localparam int IFD_CODE_W = 8;
  // Function codes held in each per-input selector
  localparam logic [7:0] FC_NONE = 8'h00;
  localparam logic [7:0] FC_VEL_TRQ = 8'h19;
  localparam logic [7:0] FC_IDX3 = 8'h1A;
  localparam logic [7:0] FC_IDX4 = 8'h1B;
  localparam logic [7:0] FC_CAP_A = 8'h1C;
  localparam logic [7:0] FC_CAP_B = 8'h1D;
  localparam logic [7:0] FC_TRQ_POS = 8'h20;
  localparam logic [7:0] FC_STOP_OFF = 8'h21;
  localparam logic [7:0] FC_NEG_LIM = 8'h22;
  localparam logic [7:0] FC_POS_LIM = 8'h23;
  localparam logic [7:0] FC_ORIGIN = 8'h24;
  localparam logic [7:0] FC_HOME = 8'h27;
  localparam logic [7:0] FC_PULSE_SPD = 8'h2C;
  localparam logic [7:0] FC_JOG_FWD = 8'h37;
  localparam logic [7:0] FC_JOG_BWD = 8'h38;
  localparam logic [7:0] FC_ADVANCE = 8'h39;
  localparam logic [7:0] FC_RETREAT = 8'h40;
  // Inputs allowed to carry the capture codes (zero based)
  localparam int CAP_A_INPUT = 6;
  localparam int CAP_B_INPUT = 5;
  // Register byte offsets
  localparam logic [7:0] OFS_SEL_LO = 8'h00;
  localparam logic [7:0] OFS_SEL_HI = 8'h04;
  localparam logic [7:0] OFS_CONFIG = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
  localparam logic [7:0] OFS_LEVELS = 8'h18;
  // Config field positions
  localparam int CFG_POS_MODE = 0; // 0 pulse following, 1 sequence
  localparam int CFG_PULSE_HS = 1; // pulse type setting: high speed
  localparam int CFG_DIR_INV = 2; // 0 = default direction
  localparam int CFG_W = 3;
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [31:0] SEL_RST = 32'h0000_0000;
  // Interrupt event bit positions
  localparam int EV_NEG_LIM = 0;
  localparam int EV_POS_LIM = 1;
  localparam int EV_CAP_A = 2;
  localparam int EV_CAP_B = 3;
  localparam int EV_STOP_OFF = 4;
  localparam int EV_W = 5;
  localparam logic [EV_W-1:0] EV_RST = 5'h00;
  typedef enum logic [1:0] {MODE_VEL, MODE_TRQ, MODE_PULSE, MODE_SEQ} ifd_mode_t;
  typedef enum logic [1:0] {JOG_NONE, JOG_POS, JOG_NEG} ifd_jog_t;
endpackage

// File: logic/ifd_edge.sv
/*
  Rising-edge detector for a vector of request levels.
  Assumes levels are already synchronous to sys_clk_i.
*/
`timescale 1ns/100ps
module ifd_edge
  import ifd_pkg::*;
#(
  parameter int W = 8
)
(
  input wire logic sys_clk_i, // System clock
  input wire logic rst_n_i, // Synchronous reset, active low
  input wire logic clk_en_i, // Clock enable
  input wire logic [W-1:0] level_i, // Request levels
  output logic [W-1:0] rise_o // One-cycle pulse on rise
);
  typedef struct packed
  {
    logic [W-1:0] prev;
  } ifd_edge_st_t;
  ifd_edge_st_t st_r;
  ifd_edge_st_t st_nxt;

  // Remember last level
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.prev = level_i;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
      st_r <= '0;
    else if (clk_en_i)
      st_r <= st_nxt;
  end

  // Combinational: the top registers these pulses
  assign rise_o = level_i & ~st_r.prev;
endmodule

// File: logic/ifd_sel.sv
/*
  Function selector: ORs the levels of all allowed inputs whose code matches.
  Assumes codes and levels are stable within the cycle.
*/
`timescale 1ns/100ps
module ifd_sel
  import ifd_pkg::*;
#(
  parameter int N = IFD_NUM_IN
)
(
  input wire logic [N*IFD_CODE_W-1:0] codes_i, // Packed selectors
  input wire logic [N-1:0] level_i, // Input levels
  input wire logic [IFD_CODE_W-1:0] code_i, // Code sought
  input wire logic [N-1:0] allow_i, // Inputs allowed for this code
  output logic hit_o // Some allowed input assigned and active
);
  // Scan every input for the code
  always_comb
  begin
    hit_o = 1'b0;
    for (int i = 0; i < N; i++)
    begin
      if (allow_i[i] && codes_i[i*IFD_CODE_W +: IFD_CODE_W] == code_i && level_i[i])
        hit_o = 1'b1;
    end
  end
endmodule

// File: verif/ifd_switch_bank.sv
/*
  Switch bank model: external contacts wired to the digital inputs.
  Assumes the bench asks for contact states just after a clock edge.
*/
`timescale 1ns/100ps
module ifd_switch_bank
(
  input wire logic sys_clk_i, // Clock
  input wire logic [7:0] want_i, // Contact states asked by the bench
  output logic [7:0] din_o // Levels seen at the inputs
);
  // Contacts settle one edge late, like a relay output; open at power-up
  initial din_o = 8'h00;
  always @(posedge sys_clk_i)
  begin
    din_o <= want_i;
  end
endmodule

// File: verif/ifd_top_assertions.sv
/*
  Assertions for the input function decoder, bound into ifd_top.
  Assumes clk_en_i stays high and a selector write lands at its access edge.
*/
`timescale 1ns/100ps
module ifd_top_assertions
  import ifd_pkg::*;
#(
  parameter int N = IFD_NUM_IN
)
(
  input wire logic sys_clk_i, // Clock
  input wire logic rst_n_i, // Sync reset, active low
  input wire logic [N-1:0] din_i, // Digital inputs
  input wire logic psel_i, // APB select
  input wire logic penable_i, // APB enable
  input wire logic pwrite_i, // APB write
  input wire logic [7:0] paddr_i, // APB address
  input wire logic [31:0] pwdata_i, // APB write data
  input wire logic pready_o, // APB ready
  input wire logic [1:0] set_index_hi_o, // Index bits 4,3
  input wire logic capture_trigger_a_o, // Capture A
  input wire logic capture_trigger_b_o, // Capture B
  input wire logic stop_and_power_off_o, // Stop request
  input wire logic power_stage_off_o, // Power stage off
  input wire logic neg_travel_limit_o, // Negative limit
  input wire logic pos_travel_limit_o, // Positive limit
  input wire logic origin_switch_o, // Reference switch
  input wire logic return_to_origin_o // Home pulse
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [63:0] codes_r;
  logic [7:0] hit;
  logic wr_ok;
  assign wr_ok = psel_i && penable_i && pready_o && pwrite_i;
  // Shadow of the selectors, so expectations need no peek inside
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
      codes_r <= '0;
    else if (wr_ok && paddr_i == OFS_SEL_LO)
      codes_r[31:0] <= pwdata_i;
    else if (wr_ok && paddr_i == OFS_SEL_HI)
      codes_r[63:32] <= pwdata_i;
  end
  // Level of each watched function; capture codes count on one pin only
  always_comb
  begin
    hit = '0;
    for (int k = 0; k < N; k++)
    begin
      hit[0] |= codes_r[8*k +: 8] == FC_IDX3 && din_i[k];
      hit[1] |= codes_r[8*k +: 8] == FC_IDX4 && din_i[k];
      hit[2] |= codes_r[8*k +: 8] == FC_NEG_LIM && din_i[k];
      hit[3] |= codes_r[8*k +: 8] == FC_POS_LIM && din_i[k];
      hit[4] |= codes_r[8*k +: 8] == FC_ORIGIN && din_i[k];
      hit[5] |= codes_r[8*k +: 8] == FC_HOME && din_i[k];
    end
    hit[6] = codes_r[8*CAP_A_INPUT +: 8] == FC_CAP_A && din_i[CAP_A_INPUT];
    hit[7] = codes_r[8*CAP_B_INPUT +: 8] == FC_CAP_B && din_i[CAP_B_INPUT];
  end
  sequence home_rise;
    !hit[5] ##1 hit[5];
  endsequence
  sequence home_pulse;
    return_to_origin_o ##1 !return_to_origin_o;
  endsequence
  AST_APB_ANSWER: assert property (psel_i && !penable_i |=> pready_o)
    else $error("no ready after setup");
  AST_READY_ONE: assert property (pready_o |=> !pready_o)
    else $error("ready held too long");
  AST_INDEX: assert property (1'b1 |=> set_index_hi_o == $past(hit[1:0]))
    else $error("index bits wrong");
  AST_CAP_A: assert property (hit[6] |=> capture_trigger_a_o)
    else $error("capture A missed");
  AST_CAP_B: assert property (capture_trigger_b_o |-> $past(hit[7]))
    else $error("capture B wrong");
  AST_POWER: assert property (power_stage_off_o |-> stop_and_power_off_o)
    else $error("power off without stop");
  AST_NEG: assert property (hit[2] |=> neg_travel_limit_o)
    else $error("neg limit missed");
  AST_POS: assert property (!hit[3] |=> !pos_travel_limit_o)
    else $error("pos limit stuck");
  AST_ORIGIN: assert property ($changed(hit[4]) |=> origin_switch_o == $past(hit[4]))
    else $error("origin level wrong");
  AST_HOME: assert property (home_rise |=> home_pulse)
    else $error("home pulse wrong");
endmodule

bind ifd_top ifd_top_assertions #(.N(N)) u_chk (.sys_clk_i, .rst_n_i, .din_i, .psel_i,
  .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pready_o, .set_index_hi_o,
  .capture_trigger_a_o, .capture_trigger_b_o, .stop_and_power_off_o, .power_stage_off_o,
  .neg_travel_limit_o, .pos_travel_limit_o, .origin_switch_o, .return_to_origin_o);

// File: verif/test_input_function_decoder.sv
/*
  Testbench for ifd_top: APB master tasks, switch bank, one task per scenario.
  Assumes the checker binds itself and clk_en_i may stay high throughout.
*/
`timescale 1ns/100ps
module test_input_function_decoder
  import ifd_pkg::*;
;
  logic sys_clk_i = 1'b0, rst_n_i = 1'b0, clk_en_i = 1'b1, motor_stopped_i = 1'b0;
  logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, rerr;
  logic [7:0] paddr_i = 8'h00, want = 8'h00, din_i;
  logic [31:0] pwdata_i = 32'h0000_0000, prdata_o, rdata;
  logic pready_o, pslverr_o, irq_o, mode_forced_o, capture_trigger_a_o, capture_trigger_b_o;
  logic stop_and_power_off_o, power_stage_off_o, neg_travel_limit_o, pos_travel_limit_o;
  logic origin_switch_o, return_to_origin_o, pulse_speed_select_o, set_advance_o, set_retreat_o;
  logic [1:0] op_mode_o, set_index_hi_o, jog_o;
  int err_total = 0;
  int samples_checked = 0;
  int n_home = 0, n_adv = 0, n_ret = 0;

  ifd_top u_dut (.sys_clk_i, .rst_n_i, .clk_en_i, .din_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .irq_o, .op_mode_o, .mode_forced_o,
    .set_index_hi_o, .capture_trigger_a_o, .capture_trigger_b_o, .stop_and_power_off_o,
    .power_stage_off_o, .neg_travel_limit_o, .pos_travel_limit_o, .origin_switch_o,
    .return_to_origin_o, .pulse_speed_select_o, .jog_o, .set_advance_o, .set_retreat_o,
    .motor_stopped_i);
  ifd_switch_bank u_sw (.sys_clk_i, .want_i(want), .din_o(din_i));

  // Clock; pulses are counted on the falling edge, clear of any update
  always #20 sys_clk_i = ~sys_clk_i;
  always @(negedge sys_clk_i)
  begin
    n_home += int'(return_to_origin_o === 1'b1);
    n_adv += int'(set_advance_o === 1'b1);
    n_ret += int'(set_retreat_o === 1'b1);
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; an idle edge after it keeps psel from being driven twice
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    // Only the watchdog ends a wait for ready
    do
      @(posedge sys_clk_i);
    while (pready_o !== 1'b1);
    rdata = prdata_o;
    rerr = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdata, exp);
  endtask

  // Partner adds one edge and the decoder one more, so three edges settle it
  task automatic press(input logic [7:0] v);
    want <= v;
    repeat (3) @(posedge sys_clk_i);
  endtask

  task automatic t_reset;
    chk(32'(op_mode_o), 32'(MODE_PULSE));
    rd(OFS_SEL_LO, SEL_RST);
    rd(OFS_CONFIG, CFG_RST);
    apb(1'b0, 8'h3C, 32'h0000_0000);
    chk(32'(rerr), 32'h0000_0001);
  endtask

  task automatic t_modes;
    apb(1'b1, OFS_SEL_LO, 32'h0000_0019);
    press(8'h00);
    chk(32'({mode_forced_o, op_mode_o}), 32'({1'b1, MODE_VEL}));
    press(8'h01);
    chk(32'(op_mode_o), 32'(MODE_TRQ));
    apb(1'b1, OFS_SEL_LO, 32'h0000_2019);
    press(8'h02);
    chk(32'(op_mode_o), 32'(MODE_PULSE));
    apb(1'b1, OFS_CONFIG, 32'h0000_0001);
    press(8'h02);
    chk(32'(op_mode_o), 32'(MODE_SEQ));
    press(8'h01);
    chk(32'(op_mode_o), 32'(MODE_TRQ));
  endtask

  task automatic t_index;
    apb(1'b1, OFS_SEL_LO, 32'h0000_1B1A);
    apb(1'b1, OFS_SEL_HI, 32'h001C_1D1C);
    press(8'h10);
    chk(32'(capture_trigger_a_o), 32'h0000_0000);
    press(8'h63);
    chk(32'({set_index_hi_o, capture_trigger_a_o, capture_trigger_b_o}), 32'h0000_000F);
    rd(OFS_LEVELS, 32'h0000_0063);
    rd(OFS_IRQ_STAT, 32'h0000_000C);
    press(8'h02);
    chk(32'(set_index_hi_o), 32'h0000_0002);
  endtask

  task automatic t_limits;
    apb(1'b1, OFS_SEL_LO, 32'h2423_2221);
    apb(1'b1, OFS_IRQ_MASK, 32'h0000_0003);
    press(8'h02);
    chk(32'({neg_travel_limit_o, irq_o}), 32'h0000_0003);
    rd(OFS_IRQ_STAT, 32'h0000_0001);
    chk(32'(irq_o), 32'h0000_0000);
    press(8'h04);
    chk(32'({neg_travel_limit_o, pos_travel_limit_o, irq_o}), 32'h0000_0003);
    rd(OFS_IRQ_STAT, 32'h0000_0002);
    apb(1'b1, OFS_IRQ_MASK, 32'h0000_0000);
    press(8'h09);
    chk(32'({stop_and_power_off_o, power_stage_off_o, origin_switch_o, irq_o}), 32'h0000_000A);
    motor_stopped_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    chk(32'(power_stage_off_o), 32'h0000_0001);
    rd(OFS_IRQ_STAT, 32'h0000_0010);
    press(8'h00);
    chk(32'({stop_and_power_off_o, power_stage_off_o, origin_switch_o}), 32'h0000_0000);
  endtask

  // Held inputs must give one pulse each; steps only count in sequence mode
  task automatic t_pulses;
    apb(1'b1, OFS_SEL_LO, 32'h3938_3727);
    apb(1'b1, OFS_SEL_HI, 32'h0000_2C40);
    apb(1'b1, OFS_CONFIG, 32'h0000_0001);
    n_home = 0;
    n_adv = 0;
    n_ret = 0;
    repeat (2)
    begin
      press(8'h19);
      press(8'h00);
    end
    apb(1'b1, OFS_CONFIG, 32'h0000_0000);
    press(8'h19);
    press(8'h00);
    chk(32'(n_home), 32'h0000_0003);
    chk(32'({n_adv[7:0], n_ret[7:0]}), 32'h0000_0202);
    press(8'h22);
    chk(32'({jog_o, pulse_speed_select_o}), 32'({JOG_POS, 1'b1}));
    press(8'h04);
    chk(32'({jog_o, pulse_speed_select_o}), 32'({JOG_NEG, 1'b0}));
    press(8'h06);
    chk(32'(jog_o), 32'(JOG_NONE));
    apb(1'b1, OFS_SEL_HI, 32'h0000_0040);
    apb(1'b1, OFS_CONFIG, 32'h0000_0006);
    press(8'h02);
    chk(32'({jog_o, pulse_speed_select_o}), 32'({JOG_NEG, 1'b1}));
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Main sequence: reset for three edges, then every scenario in turn
  initial
  begin
    repeat (3) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    t_reset();
    t_modes();
    t_index();
    t_limits();
    t_pulses();
    wrap_up();
  end

  // Watchdog well beyond the hundred and forty edges the scenarios need
  initial
  begin
    repeat (5000) @(posedge sys_clk_i);
    err_total++;
    wrap_up();
  end
endmodule
